/* File: design/mas_map.sv */
`timescale 1ns/1ps
`include "mas_defines.svh"
module mas_map #(
	parameter int PM_AW = 16,
	parameter int PAGES = `MAS_PAGES,
	parameter int LCD_BYTES = `MAS_LCD_BYTES
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Program memory port.
	input wire logic [PM_AW-1:0] pm_addr,
	input wire logic pm_rd,
	input wire logic pm_wr,
	input wire logic [7:0] pm_wdata,
	output logic [7:0] pm_rdata,
	// Boot start address.
	output logic [15:0] start_addr,
	output logic start_valid,
	// Register file port.
	input wire logic [7:0] rf_addr,
	input wire logic rf_rd,
	input wire logic rf_wr,
	input wire logic [7:0] rf_wdata,
	input wire logic rf_indirect,
	output logic [7:0] rf_rdata,
	output logic [7:0] page_pointer,
	output logic bank_sel,
	output logic lcd_hit,
	// Bank select instructions.
	input wire logic select_bank_zero_instr,
	input wire logic select_bank_one_instr
);
	localparam int PM_SIZE = 1 << PM_AW;
	logic [7:0] flash [0:PM_SIZE-1];
	logic [7:0] set1_common [0:31];
	logic [7:0] set1_bank [0:63];
	logic [7:0] paged [0:PAGES*256-1];
	logic [7:0] lcd_mem [0:LCD_BYTES-1];
	mas_pkg::mas_state_s s_q, s_d;

	logic upper;
	logic set1_hit;
	logic set2_hit;
	logic pp_hit;
	logic [3:0] rd_page;
	logic [3:0] wr_page;
	logic lcd_rd;
	logic lcd_wr;
	logic [10:0] rd_idx;
	logic [10:0] wr_idx;
	logic [5:0] bank_idx;
	logic [7:0] rf_rd_val;
	logic opt_hit;

	// Address decode for the register file and the boot option bytes.
	always_comb begin
		upper = rf_addr >= `MAS_SET_BASE; // RULE10
		set1_hit = upper && !rf_indirect; // RULE13 RULE12
		set2_hit = upper && rf_indirect; // RULE20 RULE9
		pp_hit = set1_hit && (rf_addr == `MAS_PP_ADDR); // RULE18
		rd_page = s_q.page_pointer[3:0]; // RULE16
		wr_page = s_q.page_pointer[7:4];
		lcd_rd = !set1_hit && (rd_page == `MAS_LCD_PAGE) && (rf_addr < 8'(LCD_BYTES)); // RULE15
		lcd_wr = !set1_hit && (wr_page == `MAS_LCD_PAGE) && (rf_addr < 8'(LCD_BYTES));
		rd_idx = {rd_page[2:0], rf_addr}; // RULE14
		wr_idx = {wr_page[2:0], rf_addr};
		bank_idx = {s_q.bank, rf_addr[4:0]}; // RULE11
		opt_hit = (pm_addr >= `MAS_OPT_LO) && (pm_addr <= `MAS_OPT_HI); // RULE4
	end

	// Read data path, resolved in the same cycle as the request.
	always_comb begin
		rf_rd_val = 8'h00;
		if (pp_hit) begin
			rf_rd_val = s_q.page_pointer;
		end else if (set1_hit && rf_addr >= `MAS_BANK_BASE) begin
			rf_rd_val = set1_bank[bank_idx];
		end else if (set1_hit) begin
			rf_rd_val = set1_common[rf_addr[4:0]];
		end else if (lcd_rd) begin
			rf_rd_val = lcd_mem[rf_addr[5:0]];
		end else if (rd_page < 4'(PAGES)) begin
			rf_rd_val = paged[rd_idx]; // RULE21
		end
	end

	// Next state.
	always_comb begin
		s_d = s_q;
		case (s_q.st)
			mas_pkg::MAS_ST_BOOT: begin
				s_d.boot_vec[7:0] = flash[`MAS_OPT_USED1];
				s_d.st = mas_pkg::MAS_ST_LOAD;
			end
			mas_pkg::MAS_ST_LOAD: begin
				s_d.boot_vec[15:8] = flash[`MAS_OPT_USED0];
				s_d.st = mas_pkg::MAS_ST_RUN;
			end
			mas_pkg::MAS_ST_RUN: begin
				s_d.start_valid = 1'b1;
				if (s_q.boot_vec == 16'hFFFF || s_q.boot_vec == 16'h0000) begin
					s_d.start_addr = `MAS_RESET_START; // RULE1
				end else begin
					s_d.start_addr = s_q.boot_vec;
				end
				s_d.st = mas_pkg::MAS_ST_RUN;
			end
			default: begin
				s_d.st = mas_pkg::MAS_ST_BOOT;
			end
		endcase
		if (select_bank_zero_instr) begin
			s_d.bank = 1'b0; // RULE16
		end else if (select_bank_one_instr) begin
			s_d.bank = 1'b1;
		end
		if (rf_wr && pp_hit) begin
			s_d.page_pointer = rf_wdata;
		end
		if (pm_rd) begin
			s_d.pm_rdata = flash[pm_addr]; // RULE2 RULE3 RULE6 RULE8
		end
		if (rf_rd) begin
			s_d.rf_rdata = rf_rd_val; // RULE7
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q.st <= mas_pkg::MAS_ST_BOOT;
			s_q.page_pointer <= `MAS_PP_RESET; // RULE17
			s_q.bank <= 1'b0; // RULE19
			s_q.boot_vec <= 16'h0000;
			s_q.start_addr <= `MAS_RESET_START;
			s_q.start_valid <= 1'b0;
			s_q.pm_rdata <= 8'h00;
			s_q.rf_rdata <= 8'h00;
		end else begin
			s_q <= s_d;
		end
	end

	// Storage arrays, written without reset.
	always_ff @(posedge sys_clk) begin
		if (pm_wr) begin
			flash[pm_addr] <= pm_wdata; // RULE5
		end
		if (rf_wr && !pp_hit) begin
			if (set1_hit && rf_addr >= `MAS_BANK_BASE) begin
				set1_bank[bank_idx] <= rf_wdata;
			end else if (set1_hit) begin
				set1_common[rf_addr[4:0]] <= rf_wdata;
			end else if (lcd_wr) begin
				lcd_mem[rf_addr[5:0]] <= rf_wdata;
			end else if (wr_page < 4'(PAGES)) begin
				paged[wr_idx] <= rf_wdata;
			end
		end
	end

	assign pm_rdata = s_q.pm_rdata;
	assign rf_rdata = s_q.rf_rdata;
	assign start_addr = s_q.start_addr;
	assign start_valid = s_q.start_valid;
	assign page_pointer = s_q.page_pointer;
	assign bank_sel = s_q.bank;
	assign lcd_hit = lcd_rd;

	property p_pp_reset;
		@(posedge sys_clk) $rose(nrst) |-> page_pointer == 8'h00;
	endproperty
	pp_reset_a: assert property (p_pp_reset) else $error("page pointer not cleared"); // RULE17
	bank_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		select_bank_zero_instr |=> !bank_sel) else $error("bank zero not selected"); // RULE16
	bank_one_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		select_bank_one_instr && !select_bank_zero_instr |=> bank_sel) else $error("bank one missing"); // RULE16
	pp_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		rf_wr && rf_addr == 8'hDF && !rf_indirect |=> page_pointer == $past(rf_wdata))
		else $error("page pointer write lost"); // RULE18
	set2_pp_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		rf_wr && rf_indirect |=> page_pointer == $past(page_pointer))
		else $error("indirect access hit page pointer"); // RULE20
	sequence s_boot;
		!start_valid ##1 !start_valid ##1 !start_valid;
	endsequence
	start_time_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_boot |=> start_valid) else $error("start address late"); // RULE1
	start_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		start_valid && pm_wr |=> $stable(start_addr)) else $error("boot setting changed by store"); // RULE5
	pp_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		rf_rd && !rf_wr && rf_addr == 8'hDF && !rf_indirect |=> rf_rdata == $past(page_pointer))
		else $error("page pointer read wrong"); // RULE21
	bank_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!select_bank_zero_instr && !select_bank_one_instr |=> $stable(bank_sel))
		else $error("bank changed unprompted"); // RULE11

	// Boot sequencing, start address and bank checks.
	sequence s_settled;
		start_valid ##1 start_valid;
	endsequence

	sequence s_load_run;
		s_q.st == mas_pkg::MAS_ST_LOAD ##1 s_q.st == mas_pkg::MAS_ST_RUN;
	endsequence

	sequence s_bank_swap;
		select_bank_one_instr && !select_bank_zero_instr ##1 select_bank_zero_instr;
	endsequence

	property p_opt_store;
		@(posedge sys_clk) disable iff (!nrst)
		start_valid && pm_wr && opt_hit |=> $stable(start_addr) && start_valid;
	endproperty
	opt_store_a: assert property (p_opt_store) // RULE5
		else $error("option store changed boot setting");

	property p_start_settled;
		@(posedge sys_clk) disable iff (!nrst)
		s_settled |-> $stable(start_addr);
	endproperty
	start_settled_a: assert property (p_start_settled) // RULE5
		else $error("start address moved after boot");

	property p_start_keep;
		@(posedge sys_clk) disable iff (!nrst)
		start_valid |=> start_valid;
	endproperty
	start_keep_a: assert property (p_start_keep) // RULE1
		else $error("start valid dropped");

	property p_start_default;
		@(posedge sys_clk) disable iff (!nrst)
		s_q.st == mas_pkg::MAS_ST_RUN && (s_q.boot_vec == 16'hFFFF || s_q.boot_vec == 16'h0000)
			|=> start_addr == `MAS_RESET_START;
	endproperty
	start_default_a: assert property (p_start_default) // RULE1
		else $error("default start address wrong");

	property p_start_custom;
		@(posedge sys_clk) disable iff (!nrst)
		s_q.st == mas_pkg::MAS_ST_RUN && s_q.boot_vec != 16'hFFFF && s_q.boot_vec != 16'h0000
			|=> start_addr == $past(s_q.boot_vec);
	endproperty
	start_custom_a: assert property (p_start_custom) // RULE4
		else $error("option start address wrong");

	property p_boot_walk;
		@(posedge sys_clk) disable iff (!nrst)
		s_q.st == mas_pkg::MAS_ST_BOOT |=> s_load_run;
	endproperty
	boot_walk_a: assert property (p_boot_walk) // RULE4
		else $error("boot option fetch order wrong");

	property p_run_stay;
		@(posedge sys_clk) disable iff (!nrst)
		s_q.st == mas_pkg::MAS_ST_RUN |=> s_q.st == mas_pkg::MAS_ST_RUN;
	endproperty
	run_stay_a: assert property (p_run_stay) // RULE1
		else $error("boot state left run");

	property p_state_onehot;
		@(posedge sys_clk) disable iff (!nrst)
		$onehot(s_q.st);
	endproperty
	state_onehot_a: assert property (p_state_onehot) // RULE1
		else $error("boot state not one hot");

	property p_start_reset;
		@(posedge sys_clk) $rose(nrst) |-> !start_valid && start_addr == `MAS_RESET_START;
	endproperty
	start_reset_a: assert property (p_start_reset) // RULE1
		else $error("start outputs not at reset values");

	property p_bank_reset;
		@(posedge sys_clk) $rose(nrst) |-> !bank_sel;
	endproperty
	bank_reset_a: assert property (p_bank_reset) // RULE19
		else $error("bank not zero after reset");

	property p_bank_swap;
		@(posedge sys_clk) disable iff (!nrst)
		s_bank_swap |=> !bank_sel;
	endproperty
	bank_swap_a: assert property (p_bank_swap) // RULE16
		else $error("bank swap back lost");

	// Read data holding and register decode checks.
	property p_rf_hold;
		@(posedge sys_clk) disable iff (!nrst)
		!rf_rd |=> $stable(rf_rdata);
	endproperty
	rf_hold_a: assert property (p_rf_hold) // RULE21
		else $error("register read data changed without read");

	property p_pm_hold;
		@(posedge sys_clk) disable iff (!nrst)
		!pm_rd |=> $stable(pm_rdata);
	endproperty
	pm_hold_a: assert property (p_pm_hold) // RULE6
		else $error("program read data changed without read");

	property p_pp_quiet;
		@(posedge sys_clk) disable iff (!nrst)
		!rf_wr |=> $stable(page_pointer);
	endproperty
	pp_quiet_a: assert property (p_pp_quiet) // RULE16
		else $error("page pointer changed without write");

	property p_pp_other;
		@(posedge sys_clk) disable iff (!nrst)
		rf_wr && rf_addr != `MAS_PP_ADDR |=> $stable(page_pointer);
	endproperty
	pp_other_a: assert property (p_pp_other) // RULE18
		else $error("page pointer hit by other address");

	property p_empty_page;
		@(posedge sys_clk) disable iff (!nrst)
		rf_rd && !set1_hit && !lcd_rd && rd_page >= 4'(PAGES) |=> rf_rdata == 8'h00;
	endproperty
	empty_page_a: assert property (p_empty_page) // RULE14
		else $error("missing page read not zero");

	property p_lcd_decode;
		@(posedge sys_clk) disable iff (!nrst)
		lcd_hit |-> !set1_hit && page_pointer[3:0] == `MAS_LCD_PAGE && rf_addr < 8'(LCD_BYTES);
	endproperty
	lcd_decode_a: assert property (p_lcd_decode) // RULE15
		else $error("lcd decode outside its block");

	property p_set1_visible;
		@(posedge sys_clk) disable iff (!nrst)
		set1_hit |-> !lcd_hit;
	endproperty
	set1_visible_a: assert property (p_set1_visible) // RULE12
		else $error("page hid set 1");

	property p_set2_no_pp;
		@(posedge sys_clk) disable iff (!nrst)
		rf_indirect |-> !pp_hit && !set1_hit;
	endproperty
	set2_no_pp_a: assert property (p_set2_no_pp) // RULE20
		else $error("indirect access reached set 1");

	property p_direct_set1;
		@(posedge sys_clk) disable iff (!nrst)
		!rf_indirect |-> !set2_hit;
	endproperty
	direct_set1_a: assert property (p_direct_set1) // RULE13
		else $error("direct access reached set 2");

	property p_upper_split;
		@(posedge sys_clk) disable iff (!nrst)
		upper |-> set1_hit != set2_hit;
	endproperty
	upper_split_a: assert property (p_upper_split) // RULE10
		else $error("upper range decoded twice");

	property p_lower_prime;
		@(posedge sys_clk) disable iff (!nrst)
		!upper |-> !set1_hit && !set2_hit;
	endproperty
	lower_prime_a: assert property (p_lower_prime) // RULE9
		else $error("lower range decoded as set");
endmodule

/* File: include/mas_defines.svh */
// Behaviour
// RULE1: After reset the first fetch is from 0100H unless the boot option redirects.
// RULE2: Program bytes 0H-0FFH hold the interrupt vector table.
// RULE3: Unused vector locations act as ordinary readable program memory.
// RULE4: Bytes 003CH-003FH are boot option bytes; only 003EH and 003FH matter.
// RULE5: Stores to boot option bytes change data but not the active boot setting.
// RULE6: Program memory uses a 16-bit address bus separate from the register bus.
// RULE7: Register accesses use a dedicated 8-bit address and data bus.
// RULE8: Program memory holds 64KB of code and table data.
// RULE9: 256 physical register bytes appear as 320 through addressing mode.
// RULE10: Upper 64 bytes decode as set 1 and set 2 sharing one range.
// RULE11: Set 1 upper 32 bytes form two banks; lower 32 bytes are common.
// RULE12: Set 1 is reachable whatever page is selected.
// RULE13: Set 1 decodes only for direct register mode accesses.
// RULE14: 2,048 general purpose bytes span pages 0 to 7 via the page pointer.
// RULE15: A 34-byte block of LCD data registers lives in the paged file.
// RULE16: Bank follows bank select instructions; page follows the page pointer.
// RULE17: Reset clears both page pointer nibbles, selecting page 0.
// RULE18: The page pointer sits at set 1 address DFH.
// RULE19: Reset always selects bank 0.
// RULE20: Set 2 decodes only for indirect or indexed accesses.
// RULE21: Decode is combinational so a register access completes in one cycle.
`ifndef MAS_DEFINES_SVH
`define MAS_DEFINES_SVH
`define MAS_RESET_START 16'h0100
`define MAS_VECTOR_TOP 16'h00FF
`define MAS_OPT_LO 16'h003C
`define MAS_OPT_HI 16'h003F
`define MAS_OPT_USED0 16'h003E
`define MAS_OPT_USED1 16'h003F
`define MAS_SET_BASE 8'hC0
`define MAS_BANK_BASE 8'hE0
`define MAS_PP_ADDR 8'hDF
`define MAS_PP_RESET 8'h00
`define MAS_LCD_PAGE 4'h8
`define MAS_LCD_BYTES 34
`define MAS_PAGES 8
`endif

/* File: include/mas_pkg.sv */
package mas_pkg;
	typedef enum logic [1:0] {
		MAS_MODE_DIRECT = 2'h1,
		MAS_MODE_INDIRECT = 2'h2
	} mas_mode_e;
	typedef enum logic [2:0] {
		MAS_ST_BOOT = 3'h1,
		MAS_ST_LOAD = 3'h2,
		MAS_ST_RUN = 3'h4
	} mas_state_e;
	typedef struct packed {
		mas_state_e st;
		logic [7:0] page_pointer;
		logic bank;
		logic [15:0] boot_vec;
		logic [15:0] start_addr;
		logic start_valid;
		logic [7:0] pm_rdata;
		logic [7:0] rf_rdata;
	} mas_state_s;
endpackage

/* File: tb/mas_cpu_model.sv */
`timescale 1ns/1ps
module mas_cpu_model (
	// Clock and requests toward the map.
	input wire logic sys_clk,
	output logic [15:0] pm_addr,
	output logic pm_rd,
	output logic pm_wr,
	output logic [7:0] pm_wdata,
	output logic [7:0] rf_addr,
	output logic rf_rd,
	output logic rf_wr,
	output logic [7:0] rf_wdata,
	output logic rf_indirect,
	output logic select_bank_zero_instr,
	output logic select_bank_one_instr
);
	initial begin
		{pm_addr, pm_rd, pm_wr, pm_wdata} = 26'h0;
		{rf_addr, rf_rd, rf_wr, rf_wdata, rf_indirect} = 19'h0;
		{select_bank_zero_instr, select_bank_one_instr} = 2'h0;
	end
	// Released address and data lines show the inverse of the last value; strobes return low.
	task automatic pm_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		{pm_addr, pm_wdata, pm_wr, pm_rd} = {a, d, wr, !wr};
		@(posedge sys_clk) #1;
		{pm_addr, pm_wdata, pm_wr, pm_rd} = {~a, ~d, 2'h0};
	endtask
	task automatic rf_op(input logic wr, input logic ind, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		{rf_addr, rf_wdata, rf_wr, rf_rd, rf_indirect} = {a, d, wr, !wr, ind};
		@(posedge sys_clk) #1;
		{rf_addr, rf_wdata, rf_wr, rf_rd} = {~a, ~d, 2'h0};
	endtask
	task automatic bank_op(input logic one);
		@(posedge sys_clk) #1;
		{select_bank_zero_instr, select_bank_one_instr} = {!one, one};
		@(posedge sys_clk) #1;
		{select_bank_zero_instr, select_bank_one_instr} = 2'h0;
	endtask
endmodule

/* File: tb/mas_map_bench.sv */
`timescale 1ns/1ps
module mas_map_bench;
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic [15:0] pm_addr, start_addr;
	logic [7:0] pm_wdata, pm_rdata, rf_addr, rf_wdata, rf_rdata, page_pointer;
	logic pm_rd, pm_wr, start_valid, rf_rd, rf_wr, rf_indirect, bank_sel, lcd_hit;
	logic select_bank_zero_instr, select_bank_one_instr;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [17:0] rows [12] = '{18'h2C5AA, 18'h3C555, 18'h0C5AA, 18'h1C555, 18'h21033, 18'h2DF11,
		18'h21077, 18'h0C5AA, 18'h01077, 18'h2DF00, 18'h01033, 18'h0DF00};
	always #25 sys_clk = ~sys_clk;
	mas_map mas_map_inst (.sys_clk, .nrst, .pm_addr, .pm_rd, .pm_wr, .pm_wdata, .pm_rdata, .start_addr,
		.start_valid, .rf_addr, .rf_rd, .rf_wr, .rf_wdata, .rf_indirect, .rf_rdata, .page_pointer,
		.bank_sel, .lcd_hit, .select_bank_zero_instr, .select_bank_one_instr);
	mas_cpu_model mas_cpu_model_inst (.sys_clk, .pm_addr, .pm_rd, .pm_wr, .pm_wdata, .rf_addr, .rf_rd,
		.rf_wr, .rf_wdata, .rf_indirect, .select_bank_zero_instr, .select_bank_one_instr);
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic do_reset;
		@(posedge sys_clk) #1;
		nrst = 1'h0;
		repeat (16) @(posedge sys_clk);
		chk("page_pointer", 16'h0000, {8'h00, page_pointer});
		chk("bank_sel", 16'h0000, {15'h0000, bank_sel});
		#1 nrst = 1'h1;
		repeat (4) @(posedge sys_clk);
		#1 chk("start_valid", 16'h0001, {15'h0000, start_valid});
	endtask
	task automatic pm_read(input logic [15:0] a, input logic [7:0] d);
		mas_cpu_model_inst.pm_op(1'h0, a, 8'h00);
		chk("pm_rdata", {8'h00, d}, {8'h00, pm_rdata});
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		do_reset();
		mas_cpu_model_inst.pm_op(1'h1, 16'h003E, 8'h00);
		mas_cpu_model_inst.pm_op(1'h1, 16'h003F, 8'h00);
		do_reset();
		chk("start_addr", 16'h0100, start_addr);
		mas_cpu_model_inst.pm_op(1'h1, 16'h003E, 8'h12);
		mas_cpu_model_inst.pm_op(1'h1, 16'h003F, 8'h34);
		do_reset();
		chk("start_addr", 16'h1234, start_addr);
		mas_cpu_model_inst.pm_op(1'h1, 16'h003F, 8'h55);
		pm_read(16'h003F, 8'h55);
		chk("start_addr", 16'h1234, start_addr);
		mas_cpu_model_inst.pm_op(1'h1, 16'h0010, 8'h5A);
		mas_cpu_model_inst.pm_op(1'h1, 16'hFFFF, 8'hA5);
		pm_read(16'h0010, 8'h5A);
		pm_read(16'hFFFF, 8'hA5);
		foreach (rows[i]) begin
			mas_cpu_model_inst.rf_op(rows[i][17], rows[i][16], rows[i][15:8], rows[i][7:0]);
			if (!rows[i][17]) chk("rf_rdata", {8'h00, rows[i][7:0]}, {8'h00, rf_rdata});
		end
		mas_cpu_model_inst.rf_op(1'h1, 1'h0, 8'hE0, 8'h11);
		mas_cpu_model_inst.bank_op(1'h1);
		chk("bank_sel", 16'h0001, {15'h0000, bank_sel});
		mas_cpu_model_inst.rf_op(1'h1, 1'h0, 8'hE0, 8'h22);
		mas_cpu_model_inst.rf_op(1'h0, 1'h0, 8'hE0, 8'h00);
		chk("rf_rdata", 16'h0022, {8'h00, rf_rdata});
		mas_cpu_model_inst.bank_op(1'h0);
		mas_cpu_model_inst.rf_op(1'h0, 1'h0, 8'hE0, 8'h00);
		chk("rf_rdata", 16'h0011, {8'h00, rf_rdata});
		mas_cpu_model_inst.rf_op(1'h1, 1'h0, 8'hDF, 8'h88);
		for (int k = 0; k < 2; k++) begin
			fork
				mas_cpu_model_inst.rf_op(1'h0, 1'h0, 8'h21 + 8'(k), 8'h00);
				begin
					@(posedge sys_clk) #2;
					chk("lcd_hit", 16'(1 - k), {15'h0000, lcd_hit});
				end
			join
		end
		mas_cpu_model_inst.rf_op(1'h1, 1'h0, 8'h05, 8'h3C);
		mas_cpu_model_inst.rf_op(1'h0, 1'h0, 8'h05, 8'h00);
		chk("rf_rdata", 16'h003C, {8'h00, rf_rdata});
		mas_cpu_model_inst.rf_op(1'h1, 1'h1, 8'hDF, 8'h77);
		chk("page_pointer", 16'h0088, {8'h00, page_pointer});
		mas_cpu_model_inst.bank_op(1'h1);
		do_reset();
		wrap_up();
	end
endmodule
